// File: common/spimc_pkg.sv
// Package for the serial port mode configuration block.
// Assumes a single 100 MHz core clock and a byte-wide register port.
package spimc_pkg;
   localparam logic [7:0] SPIMC_CFG2_OFFSET = 8'hE9;
   localparam logic [7:0] SPIMC_DATA_OFFSET = 8'hEA;
   localparam logic [7:0] SPIMC_STAT_OFFSET = 8'hEB;
   localparam logic [7:0] SPIMC_DIV_OFFSET = 8'hEC;
   localparam logic [7:0] SPIMC_CFG2_RESET = 8'h00;
   localparam logic [7:0] SPIMC_DIV_RESET = 8'h04;
   localparam int SPIMC_BIT_CONT = 7;
   localparam int SPIMC_BIT_EN = 6;
   localparam int SPIMC_BIT_ODO = 5;
   localparam int SPIMC_BIT_MASTER = 4;
   localparam int SPIMC_BIT_CPOL = 3;
   localparam int SPIMC_BIT_CPHA = 2;
   localparam int SPIMC_STAT_BUSY = 7;
   localparam int SPIMC_STAT_TXFULL = 1;
   localparam int SPIMC_STAT_RXVALID = 0;
   localparam logic [3:0] SPIMC_BITS_PER_BYTE = 4'h8;
   typedef enum logic [1:0] {
      SPIMC_IDLE = 2'b00,
      SPIMC_SHIFT = 2'b01,
      SPIMC_GAP = 2'b10
   } spimc_state_e;
endpackage : spimc_pkg

// File: rtl/spimc_buf2.sv
// Two-entry valid/ready buffer for transmit bytes.
// Assumes source and sink on the same clock.
module spimc_buf2 #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_reg [2];
   logic rd_ptr_reg;
   logic wr_ptr_reg;
   logic [1:0] count_reg;
   logic push;
   logic pop;

   assign in_ready = (count_reg != 2'd2);
   assign out_valid = (count_reg != 2'd0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rd_ptr_reg <= 1'b0;
         wr_ptr_reg <= 1'b0;
         count_reg <= 2'd0;
      end else if (clk_en) begin
         if (flush) begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            count_reg <= 2'd0;
         end else begin
            if (push) begin
               wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
               rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
         end
      end
   end

   // Storage needs no reset; valid is carried by count
   always_ff @(posedge ref_clk) begin
      if (clk_en && push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end
endmodule : spimc_buf2

// File: rtl/spimc_core.sv
// Serial port with mode configuration register two, master and slave roles.
// Assumes a register port on ref_clk; serial pins come from outside and are synchronised.
import spimc_pkg::*;

// Summary of operation
// - With continuous transfer off, a master sends one byte, releases select and waits an idle gap.
// - With continuous transfer on, a master sends bytes back to back while the transmit buffer holds data.
// - In continuous transfer, select stays asserted until buffer and shift register are both empty.
// - The continuous transfer bit is ignored in slave role.
// - The whole serial interface is held disabled while the enable bit is 0.
// - Drive bit 0 selects internal pull-ups; 1 makes the serial outputs open drain, pulling low only.
// - Role bit 0 makes a slave, 1 a master that generates the serial clock.
// - Polarity 0 idles the clock low with a rising first edge.
// - Polarity 1 idles the clock high with a falling first edge, swapping the edge roles.
// - Phase 0 samples on the first and every second edge and shifts out on the others.
// - Phase 1 shifts out on the first and every second edge and samples on the others.
module spimc_core #(
   parameter int DIV_WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic ss_n_in,
   output logic ss_n_out,
   output logic ss_n_oe,
   output logic pullup_en,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data
);
   logic [7:0] cfg_reg;
   logic [DIV_WIDTH-1:0] div_reg;
   spimc_state_e state_reg;
   logic [7:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic [DIV_WIDTH-1:0] tick_cnt_reg;
   logic edge_par_reg;
   logic sclk_reg;
   logic ss_n_reg;
   logic dout_reg;
   logic [7:0] rx_data_reg;
   logic rx_valid_reg;
   logic active_cpol_reg;
   logic active_cpha_reg;
   logic [2:0] sclk_sync_reg;
   logic [1:0] mosi_sync_reg;
   logic [2:0] ss_sync_reg;
   logic [1:0] miso_sync_reg;
   logic miso_in_s;
   logic tx_valid;
   logic tx_ready;
   logic [7:0] tx_data;
   logic tx_pop;
   logic wr_data_hit;
   logic tick;
   logic enabled;
   logic is_master;
   logic cont_mode;
   logic s_sclk;
   logic s_sclk_prev;
   logic s_ss_n;
   logic s_edge;
   logic s_start;
   logic m_edge;
   logic sample_now;
   logic shift_now;
   logic lead_edge;

   assign enabled = cfg_reg[SPIMC_BIT_EN];
   assign is_master = cfg_reg[SPIMC_BIT_MASTER];
   assign cont_mode = cfg_reg[SPIMC_BIT_CONT] && is_master;
   assign wr_data_hit = reg_wr && (reg_addr == SPIMC_DATA_OFFSET);

   spimc_buf2 #(
      .WIDTH(8)
   ) u_txbuf (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .flush(!enabled),
      .in_valid(wr_data_hit),
      .in_ready(tx_ready),
      .in_data(reg_wdata),
      .out_valid(tx_valid),
      .out_ready(tx_pop),
      .out_data(tx_data)
   );

   // Register writes; writes to the data port while full are dropped and show in status
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_reg <= SPIMC_CFG2_RESET;
         div_reg <= DIV_WIDTH'(SPIMC_DIV_RESET);
      end else if (clk_en && reg_wr) begin
         if (reg_addr == SPIMC_CFG2_OFFSET) begin
            cfg_reg <= {reg_wdata[7:2], 2'b00};
         end
         if (reg_addr == SPIMC_DIV_OFFSET) begin
            div_reg <= DIV_WIDTH'(reg_wdata);
         end
      end
   end

   // Read data stands one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               SPIMC_CFG2_OFFSET: reg_rdata <= cfg_reg;
               SPIMC_DATA_OFFSET: reg_rdata <= rx_data_reg;
               SPIMC_STAT_OFFSET: reg_rdata <= {state_reg != SPIMC_IDLE, 5'b00000, !tx_ready, rx_valid_reg};
               SPIMC_DIV_OFFSET: reg_rdata <= 8'(div_reg);
               default: reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // Pin inputs pass two flip-flops; the third stage only feeds edge detection
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sclk_sync_reg <= 3'b000;
         mosi_sync_reg <= 2'b00;
         ss_sync_reg <= 3'b111;
      end else if (clk_en) begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
         mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
         ss_sync_reg <= {ss_sync_reg[1:0], ss_n_in};
      end
   end
   assign s_sclk = sclk_sync_reg[1];
   assign s_sclk_prev = sclk_sync_reg[2];
   assign s_ss_n = ss_sync_reg[1];
   assign s_edge = (s_sclk != s_sclk_prev) && !s_ss_n;
   assign s_start = !s_ss_n && ss_sync_reg[2];

   // Master clock divider: one tick per half serial period
   assign tick = (tick_cnt_reg == '0);
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_reg <= '0;
      end else if (clk_en) begin
         if (state_reg == SPIMC_IDLE || tick) begin
            tick_cnt_reg <= div_reg;
         end else begin
            tick_cnt_reg <= tick_cnt_reg - 1'b1;
         end
      end
   end

   assign m_edge = is_master && state_reg == SPIMC_SHIFT && tick;
   // Leading edge is the odd edge of each bit; phase picks which one samples
   assign lead_edge = !edge_par_reg;
   assign sample_now = (m_edge || (!is_master && s_edge)) && (lead_edge ^ active_cpha_reg);
   assign shift_now = (m_edge || (!is_master && s_edge)) && !(lead_edge ^ active_cpha_reg);
   assign tx_pop = enabled && tx_valid && (
      (is_master && state_reg == SPIMC_IDLE) ||
      (is_master && cont_mode && state_reg == SPIMC_SHIFT && shift_now && bit_cnt_reg == SPIMC_BITS_PER_BYTE) ||
      (!is_master && state_reg == SPIMC_IDLE && s_start));

   // Transfer sequencer; polarity and phase are latched in idle for each frame, role and continuous bits act live
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= SPIMC_IDLE;
         shift_reg <= 8'h00;
         bit_cnt_reg <= 4'h0;
         edge_par_reg <= 1'b0;
         sclk_reg <= 1'b0;
         ss_n_reg <= 1'b1;
         dout_reg <= 1'b1;
         active_cpol_reg <= 1'b0;
         active_cpha_reg <= 1'b0;
      end else if (clk_en) begin
         if (!enabled) begin
            state_reg <= SPIMC_IDLE;
            ss_n_reg <= 1'b1;
            sclk_reg <= cfg_reg[SPIMC_BIT_CPOL];
            bit_cnt_reg <= 4'h0;
         end else begin
            case (state_reg)
               SPIMC_IDLE: begin
                  sclk_reg <= cfg_reg[SPIMC_BIT_CPOL];
                  active_cpol_reg <= cfg_reg[SPIMC_BIT_CPOL];
                  active_cpha_reg <= cfg_reg[SPIMC_BIT_CPHA];
                  edge_par_reg <= 1'b0;
                  bit_cnt_reg <= 4'h0;
                  if (tx_pop || (!is_master && s_start)) begin
                     state_reg <= SPIMC_SHIFT;
                     shift_reg <= tx_valid ? tx_data : 8'hFF;
                     dout_reg <= tx_valid ? tx_data[7] : 1'b1;
                     ss_n_reg <= !is_master;
                  end
               end
               SPIMC_SHIFT: begin
                  if (m_edge) begin
                     sclk_reg <= ~sclk_reg;
                  end
                  if (m_edge || (!is_master && s_edge)) begin
                     edge_par_reg <= ~edge_par_reg;
                  end
                  if (sample_now) begin
                     shift_reg <= {shift_reg[6:0], is_master ? miso_in_s : mosi_sync_reg[1]};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
                  if (shift_now && bit_cnt_reg != 4'h0) begin
                     if (bit_cnt_reg == SPIMC_BITS_PER_BYTE) begin
                        if (tx_pop) begin
                           shift_reg <= tx_data;
                           dout_reg <= tx_data[7];
                           bit_cnt_reg <= 4'h0;
                        end
                     end else begin
                        dout_reg <= shift_reg[7];
                     end
                  end
                  if (is_master && bit_cnt_reg == SPIMC_BITS_PER_BYTE && tick && edge_par_reg == 1'b0 &&
                      !(cont_mode && tx_valid)) begin
                     state_reg <= SPIMC_GAP;
                     // Gap must start on an even count or it would last only half a period
                     edge_par_reg <= 1'b0;
                     ss_n_reg <= 1'b1;
                     sclk_reg <= active_cpol_reg;
                  end
                  if (!is_master && (s_ss_n || bit_cnt_reg == SPIMC_BITS_PER_BYTE)) begin
                     state_reg <= SPIMC_IDLE;
                  end
               end
               SPIMC_GAP: begin
                  // Two ticks of deselect give one full serial period
                  if (tick) begin
                     edge_par_reg <= ~edge_par_reg;
                     if (edge_par_reg) begin
                        state_reg <= SPIMC_IDLE;
                     end
                  end
               end
               default: state_reg <= SPIMC_IDLE;
            endcase
         end
      end
   end

   // Sampled master input, synchronised like every pin
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         miso_sync_reg <= 2'b00;
      end else if (clk_en) begin
         miso_sync_reg <= {miso_sync_reg[0], miso_in};
      end
   end
   assign miso_in_s = miso_sync_reg[1];

   // Received byte holding register with valid/ready toward the core
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rx_data_reg <= 8'h00;
         rx_valid_reg <= 1'b0;
      end else if (clk_en) begin
         if (state_reg == SPIMC_SHIFT && sample_now && bit_cnt_reg == 4'h7) begin
            rx_data_reg <= {shift_reg[6:0], is_master ? miso_in_s : mosi_sync_reg[1]};
            rx_valid_reg <= 1'b1;
         end else if (rx_valid_reg && rx_ready) begin
            rx_valid_reg <= 1'b0;
         end
      end
   end
   assign rx_valid = rx_valid_reg;
   assign rx_data = rx_data_reg;

   // Open drain drives only a low; push-pull drives both levels with pull-ups on
   assign pullup_en = enabled && !cfg_reg[SPIMC_BIT_ODO];
   assign sclk_out = sclk_reg;
   assign sclk_oe = enabled && is_master && (!cfg_reg[SPIMC_BIT_ODO] || !sclk_reg);
   assign mosi_out = dout_reg;
   assign mosi_oe = enabled && is_master && (!cfg_reg[SPIMC_BIT_ODO] || !dout_reg);
   assign miso_out = dout_reg;
   assign miso_oe = enabled && !is_master && !s_ss_n && (!cfg_reg[SPIMC_BIT_ODO] || !dout_reg);
   assign ss_n_out = ss_n_reg;
   assign ss_n_oe = enabled && is_master && (!cfg_reg[SPIMC_BIT_ODO] || !ss_n_reg);
endmodule : spimc_core

// File: verif/spimc_core_sva.sv
// Checker for the serial port mode configuration block.
// Assumes it is bound to spimc_core and that the divider stays at its reset value.
module spimc_core_sva
   import spimc_pkg::*;
#(
   parameter int DIV_WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic sclk_out,
   input wire logic sclk_oe,
   input wire logic mosi_out,
   input wire logic mosi_oe,
   input wire logic miso_oe,
   input wire logic ss_n_out,
   input wire logic ss_n_oe,
   input wire logic pullup_en
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   localparam int GAP_MIN = 2 * (int'(SPIMC_DIV_RESET) + 1);
   logic [7:0] cfg_reg;
   logic [7:0] cfg_d;
   logic ss_d;
   logic sclk_d;
   int edge_cnt;
   int gap_cnt;
   wire logic mst = cfg_reg[SPIMC_BIT_EN] && cfg_reg[SPIMC_BIT_MASTER];
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_reg <= SPIMC_CFG2_RESET;
         cfg_d <= SPIMC_CFG2_RESET;
      end else begin
         cfg_d <= cfg_reg;
         if (reg_wr && reg_addr == SPIMC_CFG2_OFFSET) begin
            cfg_reg <= reg_wdata & 8'hFC;
         end
      end
   end
   // Edges are counted one cycle late so the last one of a frame is never lost
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ss_d <= 1'b1;
         sclk_d <= 1'b0;
         edge_cnt <= 0;
         gap_cnt <= 0;
      end else begin
         ss_d <= ss_n_out;
         sclk_d <= sclk_out;
         if (!ss_d) begin
            edge_cnt <= edge_cnt + int'(sclk_out != sclk_d);
         end else if (ss_n_out) begin
            edge_cnt <= 0;
         end
         gap_cnt <= ss_n_out ? ((gap_cnt < 1000) ? gap_cnt + 1 : gap_cnt) : 0;
      end
   end
   property p_off;
      !cfg_reg[SPIMC_BIT_EN] && !cfg_d[SPIMC_BIT_EN] |-> !(sclk_oe || mosi_oe || miso_oe || ss_n_oe);
   endproperty
   a_off: assert property (p_off) else $error("pin driven while disabled");
   property p_pull;
      pullup_en == (cfg_reg[SPIMC_BIT_EN] && !cfg_reg[SPIMC_BIT_ODO]);
   endproperty
   a_pull: assert property (p_pull) else $error("pull-up enable wrong");
   property p_od;
      cfg_reg[SPIMC_BIT_ODO] |-> !(sclk_oe && sclk_out) && !(mosi_oe && mosi_out) && !(ss_n_oe && ss_n_out);
   endproperty
   a_od: assert property (p_od) else $error("open drain pin driven high");
   property p_slave;
      !cfg_reg[SPIMC_BIT_MASTER] && !cfg_d[SPIMC_BIT_MASTER] |-> !sclk_oe && !ss_n_oe;
   endproperty
   a_slave: assert property (p_slave) else $error("slave drives clock or select");
   property p_idle;
      mst && $changed(ss_n_out) |-> sclk_out == cfg_reg[SPIMC_BIT_CPOL];
   endproperty
   a_idle: assert property (p_idle) else $error("clock not at idle level");
   property p_one;
      mst && !cfg_reg[SPIMC_BIT_CONT] && $rose(ss_n_out) |=> edge_cnt == 16;
   endproperty
   a_one: assert property (p_one) else $error("single byte frame length wrong");
   property p_cont;
      mst && cfg_reg[SPIMC_BIT_CONT] && $rose(ss_n_out) |=> edge_cnt % 16 == 0 && edge_cnt > 0;
   endproperty
   a_cont: assert property (p_cont) else $error("continuous frame not whole bytes");
   property p_gap;
      mst && $fell(ss_n_out) |-> gap_cnt >= GAP_MIN;
   endproperty
   a_gap: assert property (p_gap) else $error("idle gap too short");
   property p_hold;
      mst && !ss_n_out && $changed(sclk_out) && sclk_out != (cfg_reg[SPIMC_BIT_CPOL] ^ cfg_reg[SPIMC_BIT_CPHA])
         |-> $stable(mosi_out);
   endproperty
   a_hold: assert property (p_hold) else $error("data moved on sampling edge");
   property p_rd;
      reg_rd && reg_addr == SPIMC_CFG2_OFFSET |=> reg_rdata == $past(cfg_reg);
   endproperty
   a_rd: assert property (p_rd) else $error("config readback wrong");
endmodule : spimc_core_sva

bind spimc_core spimc_core_sva #(.DIV_WIDTH(DIV_WIDTH)) chk_u (.*);

// File: verif/spimc_slave_model.sv
// Behavioural far-side slave for master-role traffic.
// Assumes resolved pin levels; mode bits are handed in by the bench.
module spimc_slave_model (
   input wire logic sclk,
   input wire logic ss_n,
   input wire logic mosi,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [7:0] tx_byte,
   output logic miso,
   output logic [7:0] rx_byte,
   output int edges,
   output int frames
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh;
   initial begin
      miso = 1'b1;
      sh = 8'h00;
      rx_byte = 8'h00;
      edges = 0;
      frames = 0;
   end
   task put_bit;
      miso = sh[7];
      sh = {sh[6:0], 1'b0};
   endtask : put_bit
   always @(negedge ss_n) begin
      sh = tx_byte;
      edges = 0;
      frames++;
      if (!cpha) begin
         put_bit();
      end
   end
   // Released line shows a fresh level, never the old bit
   always @(posedge ss_n) begin
      miso = ~miso;
   end
   always @(sclk) begin
      if (!ss_n) begin
         edges++;
         if ((sclk != cpol) ^ cpha) begin
            rx_byte = {rx_byte[6:0], mosi};
         end else begin
            put_bit();
         end
      end
   end
endmodule : spimc_slave_model

// File: verif/spimc_core_tb_top.sv
// Bench for the serial port mode configuration block with a slave on its pins.
// Assumes the divider stays at reset, so a byte takes some 80 cycles.
module spimc_core_tb_top
   import spimc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic rx_ready = 1'b0;
   logic cpol = 1'b0;
   logic cpha = 1'b0;
   logic [7:0] stx = 8'h00;
   logic [7:0] reg_rdata, rx_data, srx;
   logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_n_out, ss_n_oe, pullup_en, rx_valid, smiso;
   int edges, frames;
   int bad_count = 0;
   int checks_done = 0;
   // Undriven clock, mosi and select pins settle at the pull-up level; miso falls back to the slave model
   wire logic sclk_w = sclk_oe ? sclk_out : 1'b1;
   wire logic mosi_w = mosi_oe ? mosi_out : 1'b1;
   wire logic ss_w = ss_n_oe ? ss_n_out : 1'b1;
   wire logic miso_w = miso_oe ? miso_out : smiso;
   spimc_core dut_u (.*, .clk_en(1'b1), .sclk_in(sclk_w), .mosi_in(mosi_w), .miso_in(miso_w), .ss_n_in(ss_w));
   spimc_slave_model slv_u (.sclk(sclk_w), .ss_n(ss_w), .mosi(mosi_w), .cpol(cpol), .cpha(cpha), .tx_byte(stx),
      .miso(smiso), .rx_byte(srx), .edges(edges), .frames(frames));
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   task wrap_up();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task wait_idle();
      logic [7:0] s;
      int n;
      repeat (3) @(posedge ref_clk);
      s = 8'h80;
      for (n = 0; n < 300 && s[SPIMC_STAT_BUSY] !== 1'b0; n++) begin
         rd(SPIMC_STAT_OFFSET, s);
      end
      chk(s & 8'h80, 8'h00);
   endtask : wait_idle
   task drain();
      @(posedge ref_clk);
      rx_ready <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rx_ready <= 1'b0;
   endtask : drain
   task t_regs();
      logic [7:0] v;
      rd(SPIMC_CFG2_OFFSET, v);
      chk(v, SPIMC_CFG2_RESET);
      wr(SPIMC_CFG2_OFFSET, 8'hFF);
      rd(SPIMC_CFG2_OFFSET, v);
      chk(v, 8'hFC);
      rd(8'h00, v);
      chk(v, 8'h00);
   endtask : t_regs
   task t_modes();
      int m;
      for (m = 0; m < 4; m++) begin
         cpol <= m[1];
         cpha <= m[0];
         stx <= 8'h96 ^ 8'(m);
         wr(SPIMC_CFG2_OFFSET, 8'h50 | 8'(m << 2) | (m == 3 ? 8'h20 : 8'h00));
         #1 chk({7'h00, pullup_en}, {7'h00, m != 3});
         wr(SPIMC_DATA_OFFSET, 8'h3C + 8'(m));
         wait_idle();
         chk(srx, 8'h3C + 8'(m));
         chk(rx_data, 8'h96 ^ 8'(m));
         chk(8'(edges), 8'h10);
         chk({7'h00, rx_valid}, 8'h01);
         drain();
         chk({7'h00, rx_valid}, 8'h00);
      end
   endtask : t_modes
   task t_single();
      int f0;
      int n;
      cpol <= 1'b0;
      cpha <= 1'b0;
      f0 = frames;
      wr(SPIMC_CFG2_OFFSET, 8'h50);
      wr(SPIMC_DATA_OFFSET, 8'hA1);
      wr(SPIMC_DATA_OFFSET, 8'h5E);
      for (n = 0; n < 400 && frames < f0 + 2; n++) begin
         @(posedge ref_clk);
      end
      wait_idle();
      chk(8'(frames - f0), 8'h02);
      chk(srx, 8'h5E);
      chk(8'(edges), 8'h10);
      drain();
   endtask : t_single
   task t_cont();
      logic [7:0] s;
      int f0;
      f0 = frames;
      wr(SPIMC_CFG2_OFFSET, 8'hD0);
      repeat (4) wr(SPIMC_DATA_OFFSET, 8'hC3);
      rd(SPIMC_STAT_OFFSET, s);
      chk(s & 8'h02, 8'h02);
      wait_idle();
      chk(8'(frames - f0), 8'h01);
      chk(8'(edges), 8'h30);
      drain();
   endtask : t_cont
   task t_slave();
      int f0;
      f0 = frames;
      wr(SPIMC_CFG2_OFFSET, 8'hC0);
      wr(SPIMC_DATA_OFFSET, 8'h77);
      repeat (200) @(posedge ref_clk);
      chk(8'(frames - f0), 8'h00);
      chk({6'h00, sclk_oe, ss_n_oe}, 8'h00);
   endtask : t_slave
   task t_off();
      int f0;
      f0 = frames;
      wr(SPIMC_CFG2_OFFSET, 8'h10);
      wr(SPIMC_DATA_OFFSET, 8'h11);
      repeat (100) @(posedge ref_clk);
      wr(SPIMC_CFG2_OFFSET, 8'h50);
      repeat (200) @(posedge ref_clk);
      chk(8'(frames - f0), 8'h00);
   endtask : t_off
   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      t_regs();
      t_modes();
      t_single();
      t_cont();
      t_slave();
      t_off();
      wrap_up();
   end
   // Whole run needs under 5000 cycles; four times that means a hang
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      wrap_up();
   end
endmodule : spimc_core_tb_top
